/* verilog/lcw_defs.vh */
// Constants of the level correction and window switch block.
//==========================================================
`ifndef LCW_DEFS_VH
`define LCW_DEFS_VH
`define LCW_MODE_NONE 2'h0
`define LCW_MODE_OFFSET 2'h1
`define LCW_MODE_TWO_POINT 2'h2
`define LCW_MODE_TABLE 2'h3
`define LCW_DRIVE_OFF 2'h0
`define LCW_DRIVE_PUSH_PULL 2'h1
`define LCW_DRIVE_HIGH_SIDE 2'h2
`define LCW_DRIVE_LOW_SIDE 2'h3
`define LCW_TABLE_MAX 30
`define LCW_TABLE_MIN 3
`define LCW_ENTRY_LIMIT 200000
`define LCW_HYST_MIN (-33333)
`define LCW_HYST_MAX 33000
`define LCW_LOWER_DEFAULT 10
`define LCW_UPPER_DEFAULT 90
`define LCW_ST_IDLE 2'h0
`define LCW_ST_SEARCH 2'h1
`define LCW_ST_DIVIDE 2'h2
`define LCW_ST_DONE 2'h3
`endif

/* verilog/lcw_level_switch.v */
// Level correction, hysteretic switching window and output driver.
`include "lcw_defs.vh"

module lcw_level_switch #(
  parameter W = 32,
  parameter TABLE_MAX = `LCW_TABLE_MAX,
  parameter IDX_W = 5,
  parameter signed [W-1:0] LOWER_DEFAULT = `LCW_LOWER_DEFAULT,
  parameter signed [W-1:0] UPPER_DEFAULT = `LCW_UPPER_DEFAULT
) (
  input wire clk,
  input wire rst_n,
  input wire sample_valid,
  input wire signed [W-1:0] measured_level,
  input wire [1:0] correction_mode,
  input wire signed [W-1:0] offset_value,
  input wire signed [W-1:0] two_point_meas0,
  input wire signed [W-1:0] two_point_meas1,
  input wire signed [W-1:0] two_point_corr0,
  input wire signed [W-1:0] two_point_corr1,
  input wire [IDX_W-1:0] table_length,
  input wire table_write,
  input wire [IDX_W-1:0] table_index,
  input wire signed [W-1:0] table_meas_data,
  input wire signed [W-1:0] table_corr_data,
  input wire limits_write,
  input wire signed [W-1:0] lower_limit_data,
  input wire signed [W-1:0] upper_limit_data,
  input wire signed [W-1:0] hysteresis,
  input wire invert_polarity,
  input wire [1:0] drive_mode,
  output reg signed [W-1:0] corrected_level,
  output reg corrected_valid,
  output reg window_active,
  output reg high_side_drive,
  output reg low_side_drive,
  output reg config_error
);

  //==========================================================
  // Storage.
  reg signed [W-1:0] tab_meas_reg [0:TABLE_MAX-1];
  reg signed [W-1:0] tab_corr_reg [0:TABLE_MAX-1];
  reg signed [W-1:0] window_lower_limit;
  reg signed [W-1:0] window_upper_limit;
  reg [1:0] state_reg;
  reg [IDX_W-1:0] seg_reg;
  reg signed [W-1:0] x_reg;
  reg signed [2*W-1:0] num_reg;
  reg signed [W-1:0] den_reg;
  reg signed [W-1:0] base_reg;
  reg [IDX_W:0] div_cnt_reg;
  reg [2*W-1:0] quo_reg;
  reg [2*W-1:0] rem_reg;
  reg neg_reg;
  reg signed [W-1:0] result_next;
  reg [IDX_W-1:0] len_reg;
  reg high_next;
  reg low_next;

  // Range check of a signed entry against the accepted span.
  function in_range;
    input signed [W-1:0] v;
    begin
      in_range = (v <= `LCW_ENTRY_LIMIT) && (v >= -`LCW_ENTRY_LIMIT);
    end
  endfunction

  // Inclusive window test; used with the bare limits to enter the window and,
  // with the limits pushed out by the hysteresis, to stay inside it.
  function in_window;
    input signed [W-1:0] level;
    input signed [W-1:0] lo;
    input signed [W-1:0] hi;
    begin
      in_window = (level >= lo) && (level <= hi);
    end
  endfunction

  // Output state after polarity: high while active unless inverted.
  function out_state;
    input act;
    input inv;
    begin
      out_state = act ^ inv;
    end
  endfunction

  //==========================================================
  // Table and window limit writes; limits come up at their defaults.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_lower_limit <= LOWER_DEFAULT;
      window_upper_limit <= UPPER_DEFAULT;
      config_error <= 1'b0;
    end else begin
      if (limits_write) begin
        window_lower_limit <= lower_limit_data;
        window_upper_limit <= upper_limit_data;
      end
      // Out-of-range settings are flagged; the block keeps running on them.
      config_error <= (hysteresis < `LCW_HYST_MIN) || (hysteresis > `LCW_HYST_MAX)
        || (correction_mode == `LCW_MODE_TABLE && (table_length < `LCW_TABLE_MIN
        || table_length > TABLE_MAX));
    end
  end

  // Table entries are plain memory with no reset; a write beyond range is dropped.
  always @(posedge clk) begin
    if (table_write && table_index < TABLE_MAX && in_range(table_meas_data)
        && in_range(table_corr_data)) begin
      tab_meas_reg[table_index] <= table_meas_data;
      tab_corr_reg[table_index] <= table_corr_data;
    end
  end

  //==========================================================
  // Correction engine: one segment per cycle search, then a serial divide.
  // The serial divider trades latency for area; a sample takes up to 64 cycles.
  // Offset and bypass answer in one cycle. Two-point goes straight to the
  // divider; table mode first walks the segments, one per cycle.
  // Samples that arrive while the engine is busy are ignored, so the
  // source must wait for the result strobe before offering the next level.
  // The table length is captured with the sample, so a length change while a
  // search runs cannot move the end segment under it. Table writes during a
  // search are not blocked; whoever loads the table should do so while idle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `LCW_ST_IDLE;
      seg_reg <= {IDX_W{1'b0}};
      x_reg <= {W{1'b0}};
      num_reg <= {2*W{1'b0}};
      den_reg <= {W{1'b0}};
      base_reg <= {W{1'b0}};
      div_cnt_reg <= {(IDX_W+1){1'b0}};
      quo_reg <= {2*W{1'b0}};
      rem_reg <= {2*W{1'b0}};
      neg_reg <= 1'b0;
      len_reg <= {IDX_W{1'b0}};
      corrected_level <= {W{1'b0}};
      corrected_valid <= 1'b0;
    end else begin
      corrected_valid <= 1'b0;
      case (state_reg)
        `LCW_ST_IDLE: begin
          if (sample_valid) begin
            x_reg <= measured_level;
            // Length held for the whole search of this sample.
            len_reg <= table_length;
            case (correction_mode)
              `LCW_MODE_NONE: begin
                corrected_level <= measured_level;
                corrected_valid <= 1'b1;
              end
              `LCW_MODE_OFFSET: begin
                corrected_level <= measured_level + offset_value;
                corrected_valid <= 1'b1;
              end
              `LCW_MODE_TWO_POINT: begin
                // Line through (meas0,corr0) and (meas1,corr1).
                num_reg <= (measured_level - two_point_meas0)
                  * (two_point_corr1 - two_point_corr0);
                den_reg <= two_point_meas1 - two_point_meas0;
                base_reg <= two_point_corr0;
                state_reg <= `LCW_ST_DIVIDE;
                div_cnt_reg <= {(IDX_W+1){1'b0}};
              end
              default: begin
                seg_reg <= {IDX_W{1'b0}};
                state_reg <= `LCW_ST_SEARCH;
              end
            endcase
          end
        end
        `LCW_ST_SEARCH: begin
          // Pick the first segment whose upper end reaches the level; the ends
          // extrapolate from the first or last segment.
          if (x_reg <= tab_meas_reg[seg_reg + 1'b1] || seg_reg + 2'h2 >= len_reg
              || seg_reg + 2'h2 >= TABLE_MAX) begin
            num_reg <= (x_reg - tab_meas_reg[seg_reg])
              * (tab_corr_reg[seg_reg + 1'b1] - tab_corr_reg[seg_reg]);
            den_reg <= tab_meas_reg[seg_reg + 1'b1] - tab_meas_reg[seg_reg];
            base_reg <= tab_corr_reg[seg_reg];
            state_reg <= `LCW_ST_DIVIDE;
            div_cnt_reg <= {(IDX_W+1){1'b0}};
          end else begin
            seg_reg <= seg_reg + 1'b1;
          end
        end
        `LCW_ST_DIVIDE: begin
          if (div_cnt_reg == {(IDX_W+1){1'b0}}) begin
            // Load magnitudes; the sign is reapplied at the end.
            neg_reg <= num_reg[2*W-1] ^ den_reg[W-1];
            quo_reg <= num_reg[2*W-1] ? -num_reg : num_reg;
            rem_reg <= {2*W{1'b0}};
            div_cnt_reg <= div_cnt_reg + 1'b1;
            if (den_reg == {W{1'b0}}) begin
              // Degenerate points: hold the base value rather than divide by zero.
              corrected_level <= base_reg;
              corrected_valid <= 1'b1;
              state_reg <= `LCW_ST_IDLE;
            end
          end else begin
            // Restoring division, two quotient bits per cycle.
            {rem_reg, quo_reg} <= div2({rem_reg, quo_reg},
              den_reg[W-1] ? -den_reg : den_reg);
            if (div_cnt_reg == W[IDX_W:0]) begin
              state_reg <= `LCW_ST_DONE;
            end else begin
              div_cnt_reg <= div_cnt_reg + 1'b1;
            end
          end
        end
        `LCW_ST_DONE: begin
          corrected_level <= result_next;
          corrected_valid <= 1'b1;
          state_reg <= `LCW_ST_IDLE;
        end
        default: begin
          state_reg <= `LCW_ST_IDLE;
        end
      endcase
    end
  end

  // Two restoring division steps on the joined remainder and quotient.
  function [4*W-1:0] div2;
    input [4*W-1:0] rq;
    input [W-1:0] d;
    reg [4*W-1:0] t;
    integer k;
    begin
      t = rq;
      for (k = 0; k < 2; k = k + 1) begin
        t = {t[4*W-2:0], 1'b0};
        if (t[4*W-1:2*W] >= {{W{1'b0}}, d}) begin
          t[4*W-1:2*W] = t[4*W-1:2*W] - {{W{1'b0}}, d};
          t[0] = 1'b1;
        end
      end
      div2 = t;
    end
  endfunction

  // Signed quotient added to the segment base.
  always @* begin
    result_next = base_reg + (neg_reg ? -quo_reg[W-1:0] : quo_reg[W-1:0]);
  end

  //==========================================================
  // Drive decode, kept apart from the flops so every mode names both switches.
  // Push-pull takes one switch as the complement of the other, so the two can
  // never conduct together and short the supply.
  always @* begin
    high_next = 1'b0;
    low_next = 1'b0;
    case (drive_mode)
      `LCW_DRIVE_PUSH_PULL: begin
        high_next = out_state(window_active, invert_polarity);
        low_next = ~out_state(window_active, invert_polarity);
      end
      `LCW_DRIVE_HIGH_SIDE: begin
        high_next = out_state(window_active, invert_polarity);
      end
      `LCW_DRIVE_LOW_SIDE: begin
        low_next = out_state(window_active, invert_polarity);
      end
      default: begin
        high_next = 1'b0;
        low_next = 1'b0;
      end
    endcase
  end

  //==========================================================
  // Window with hysteresis, then the registered drive switches.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_active <= 1'b0;
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
    end else begin
      if (corrected_valid) begin
        if (!window_active) begin
          // Entry uses the bare limits, so a level in the hysteresis band
          // that arrives from outside does not switch.
          window_active <= in_window(corrected_level, window_lower_limit,
            window_upper_limit);
        end else begin
          window_active <= in_window(corrected_level, window_lower_limit - hysteresis,
            window_upper_limit + hysteresis);
        end
      end
      high_side_drive <= high_next;
      low_side_drive <= low_next;
    end
  end

endmodule // lcw_level_switch

/* test/lcw_properties.sv */
// Port-level checker for the level correction and window switch block.
module lcw_properties #(parameter W = 32) (
  input wire clk,
  input wire rst_n,
  input wire signed [W-1:0] measured_level,
  input wire [1:0] correction_mode,
  input wire signed [W-1:0] offset_value,
  input wire limits_write,
  input wire signed [W-1:0] lower_limit_data,
  input wire signed [W-1:0] upper_limit_data,
  input wire signed [W-1:0] hysteresis,
  input wire invert_polarity,
  input wire [1:0] drive_mode,
  input wire signed [W-1:0] corrected_level,
  input wire corrected_valid,
  input wire window_active,
  input wire high_side_drive,
  input wire low_side_drive,
  input wire config_error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [W-1:0] lo_reg;
  logic signed [W-1:0] hi_reg;
  // Shadow of the window limits, so the window checks need no internal probes.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_reg <= 10;
      hi_reg <= 90;
    end else if (limits_write) begin
      lo_reg <= lower_limit_data;
      hi_reg <= upper_limit_data;
    end
  end
  //==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_drive_off:
    assert property ($past(drive_mode) == 2'h0 |-> !high_side_drive && !low_side_drive)
      else $error("drive switch on while output off");
  a_never_both:
    assert property (!(high_side_drive && low_side_drive))
      else $error("both drive switches on");
  a_push_pull:
    assert property ($past(rst_n) && $past(drive_mode) == 2'h1 |-> low_side_drive == !high_side_drive
      && high_side_drive == ($past(window_active) ^ $past(invert_polarity)))
      else $error("push-pull drive wrong");
  a_high_side:
    assert property ($past(rst_n) && $past(drive_mode) == 2'h2 |-> !low_side_drive
      && high_side_drive == ($past(window_active) ^ $past(invert_polarity)))
      else $error("high-side drive wrong");
  a_low_side:
    assert property ($past(rst_n) && $past(drive_mode) == 2'h3 |-> !high_side_drive
      && low_side_drive == ($past(window_active) ^ $past(invert_polarity)))
      else $error("low-side drive wrong");
  a_no_correct:
    assert property (corrected_valid && $past(correction_mode) == 2'h0
      |-> corrected_level == $past(measured_level))
      else $error("uncorrected level altered");
  a_offset_add:
    assert property (corrected_valid && $past(correction_mode) == 2'h1
      |-> corrected_level == $past(measured_level) + $past(offset_value))
      else $error("offset level wrong");
  a_window_set:
    assert property ($past(corrected_valid) && $past(corrected_level) >= lo_reg
      && $past(corrected_level) <= hi_reg |-> window_active)
      else $error("window not active inside limits");
  a_window_drop:
    assert property ($past(corrected_valid) && ($past(corrected_level) < lo_reg - $past(hysteresis)
      || $past(corrected_level) > hi_reg + $past(hysteresis)) |-> !window_active)
      else $error("window active beyond hysteresis");
  a_window_hold:
    assert property (!$past(corrected_valid) |-> $stable(window_active))
      else $error("window moved without a result");
  a_hyst_range:
    assert property ((hysteresis > 33000 || hysteresis < -33333) [*3] |-> config_error)
      else $error("hysteresis out of range not flagged");
endmodule // lcw_properties

/* test/lcw_load_model.sv */
// Load wired to the switching output, with a pull-down when nothing drives.
module lcw_load_model #(parameter PULL = 1'b0) (
  input wire high_side_drive,
  input wire low_side_drive,
  output wire pin_level,
  output wire load_current
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin falls to the pull level rather than keeping its last value.
  assign pin_level = high_side_drive ? 1'b1 : (low_side_drive ? 1'b0 : PULL);
  assign load_current = high_side_drive | low_side_drive;
endmodule // lcw_load_model

/* test/lcw_testbench.sv */
// Self-checking bench of the level correction and window switch block.
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0d seen %0d", n, e, v); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n = 0, sample_valid = 0, table_write = 0, limits_write = 0, invert_polarity = 0;
  logic signed [31:0] measured_level = 0, offset_value = 0, hysteresis = 0;
  logic signed [31:0] two_point_meas0 = 0, two_point_meas1 = 130;
  logic signed [31:0] two_point_corr0 = 0, two_point_corr1 = 100;
  logic signed [31:0] table_meas_data = 0, table_corr_data = 0;
  logic signed [31:0] lower_limit_data = 0, upper_limit_data = 0;
  logic [1:0] correction_mode = 0, drive_mode = 1;
  logic [4:0] table_length = 3, table_index = 0;
  wire signed [31:0] corrected_level;
  wire corrected_valid, window_active, high_side_drive, low_side_drive, config_error;
  wire pin_level, load_current;
  int bad_count = 0, checks = 0;
  lcw_level_switch uut (.*);
  lcw_load_model lm (.high_side_drive, .low_side_drive, .pin_level, .load_current);
  //==========================================================
  // Clock and shared tasks
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One sample; returns once window and drives have had time to follow.
  task smp(input logic signed [31:0] x);
    int i;
    @(posedge clk);
    sample_valid <= 1'b1;
    measured_level <= x;
    @(posedge clk);
    sample_valid <= 1'b0;
    i = 0;
    @(negedge clk);
    while (corrected_valid !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (i == 100) bad_count++;
    repeat (2) @(negedge clk);
  endtask
  task step(input logic signed [31:0] x, input logic e);
    smp(x);
    `CHK("window_active", e, window_active)
  endtask
  task twr(input logic [4:0] idx, input logic signed [31:0] m, input logic signed [31:0] c);
    @(posedge clk);
    table_write <= 1'b1;
    table_index <= idx;
    table_meas_data <= m;
    table_corr_data <= c;
    @(posedge clk);
    table_write <= 1'b0;
  endtask
  //==========================================================
  // Scenarios
  task t_defaults;
    step(10, 1'b1);
    step(91, 1'b0);
    step(90, 1'b1);
    step(9, 1'b0);
  endtask
  task t_hyst;
    @(posedge clk);
    limits_write <= 1'b1;
    lower_limit_data <= 30;
    upper_limit_data <= 60;
    hysteresis <= 2;
    @(posedge clk);
    limits_write <= 1'b0;
    step(30, 1'b1);
    step(28, 1'b1);
    step(27, 1'b0);
    step(29, 1'b0);
    step(62, 1'b0);
    step(60, 1'b1);
    step(62, 1'b1);
    step(63, 1'b0);
  endtask
  task t_modes;
    @(posedge clk) offset_value <= -5;
    @(posedge clk) correction_mode <= 2'h1;
    smp(50);
    `CHK("offset", 45, corrected_level)
    @(posedge clk) correction_mode <= 2'h2;
    smp(65);
    `CHK("two_point_mid", 50, corrected_level)
    smp(130);
    `CHK("two_point_end", 100, corrected_level)
    twr(0, 0, 0);
    twr(1, 10, 20);
    twr(2, 20, 30);
    twr(1, 10, 300000);
    @(posedge clk) correction_mode <= 2'h3;
    smp(15);
    `CHK("table_mid", 25, corrected_level)
    smp(10);
    `CHK("table_point", 20, corrected_level)
    @(posedge clk) table_length <= 5'h02;
    repeat (3) @(negedge clk);
    `CHK("short_table", 1'b1, config_error)
    @(posedge clk) table_length <= 5'h03;
    repeat (3) @(negedge clk);
    `CHK("table_ok", 1'b0, config_error)
    @(posedge clk) correction_mode <= 2'h0;
    smp(77);
    `CHK("no_correction", 77, corrected_level)
  endtask
  task t_drive(input logic act);
    logic a, eh, el;
    for (int d = 0; d < 4; d++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        drive_mode <= d[1:0];
        invert_polarity <= p[0];
        repeat (2) @(negedge clk);
        a = act ^ p[0];
        eh = (d == 1 || d == 2) && a;
        el = (d == 1) ? !a : (d == 3 && a);
        `CHK("high_side", eh, high_side_drive)
        `CHK("low_side", el, low_side_drive)
        `CHK("pin", eh, pin_level)
        `CHK("load", eh | el, load_current)
      end
    end
  endtask
  task hset(input logic signed [31:0] v, input logic e);
    @(posedge clk) hysteresis <= v;
    repeat (3) @(negedge clk);
    `CHK("config_error", e, config_error)
  endtask
  //==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults;
    t_hyst;
    t_modes;
    step(45, 1'b1);
    t_drive(1'b1);
    step(80, 1'b0);
    t_drive(1'b0);
    hset(40000, 1'b1);
    hset(-33333, 1'b0);
    hset(-33334, 1'b1);
    hset(33000, 1'b0);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule // testbench
bind lcw_level_switch lcw_properties #(.W(W)) u_props (.*);
